/* hw/reset_seq_pkg.sv */
package reset_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int DELAY_SHORT_CYC = 256;
  localparam int DELAY_LONG_CYC = 4096;
  localparam int DELAY_CNT_W = 12;
  localparam logic [DELAY_CNT_W-1:0] DELAY_SHORT_LOAD = DELAY_CNT_W'(DELAY_SHORT_CYC - 1);
  localparam logic [DELAY_CNT_W-1:0] DELAY_LONG_LOAD = DELAY_CNT_W'(DELAY_LONG_CYC - 1);
  // length of the active phase for internal causes that are only a pulse
  localparam int ACTIVE_CNT_W = 6;
  localparam logic [ACTIVE_CNT_W-1:0] ACTIVE_PULSE_LOAD = 6'h1F;

  ////////////////////////////////////////////////////////////////////////////
  // reset vector location
  localparam logic [15:0] VEC_ADDR_HI = 16'hFFFE;
  localparam logic [15:0] VEC_ADDR_LO = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] REG_SYS_CTRL_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h2;
  localparam logic [ADDR_W-1:0] REG_VECTOR_HI = 4'h3;
  localparam logic [ADDR_W-1:0] REG_VECTOR_LO = 4'h4;

  // system_ctrl_status_reg fields
  localparam int SCS_WARN_FLAG = 0;
  localparam int SCS_OPT_LONG = 1;
  localparam int SCS_OPT_LSEN = 2;
  localparam int SCS_CAUSE_LSB = 4;
  localparam logic [DATA_W-1:0] SCS_CAUSE_MASK = 8'h70;

  // interrupt status and mask fields
  localparam int IRQ_FLAG_SET = 0;
  localparam int IRQ_FLAG_CLR = 1;
  localparam logic [DATA_W-1:0] IRQ_MASK_RST = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_USED_MASK = 8'h03;

  // option reset values until the straps are captured
  localparam logic OPT_LONG_RST = 1'b1;
  localparam logic OPT_LSEN_RST = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_DELAY = 3'b001,
    ST_FETCH_HI = 3'b010,
    ST_FETCH_LO = 3'b011,
    ST_RUN = 3'b100
  } seq_state_e;

  typedef struct packed {
    logic watchdog;
    logic lowSupply;
    logic ext;
  } cause_s;

  typedef struct packed {
    logic extLatched;
    logic lowSupplyDet;
    logic warnComp;
    logic optLongDelay;
    logic optLowSupplyEn;
  } async_in_s;

  // sticky flag update where a set in the same cycle beats a clear
  function automatic logic [DATA_W-1:0] setWinsClear(input logic [DATA_W-1:0] cur,
                                                     input logic [DATA_W-1:0] setBits,
                                                     input logic [DATA_W-1:0] clrBits);
    return (cur & ~clrBits) | setBits;
  endfunction

endpackage

/* hw/sync_two_ff.sv */
`timescale 1ns/1ps
`default_nettype none

module sync_two_ff #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_reg <= '0;
      syncOut <= '0;
    end else begin
      stage1_reg <= asyncIn;
      syncOut <= stage1_reg;
    end
  end

endmodule

`default_nettype wire

/* hw/stab_delay_counter.sv */
`timescale 1ns/1ps
`default_nettype none

module stab_delay_counter
  import reset_seq_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // control
  input wire logic load,
  input wire logic longSel,
  // status
  output logic expired
);

  logic [DELAY_CNT_W-1:0] cnt_reg;
  logic [DELAY_CNT_W-1:0] cnt_next;
  wire logic [DELAY_CNT_W-1:0] loadValue;
  wire logic cntZero;

  assign loadValue = longSel ? DELAY_LONG_LOAD : DELAY_SHORT_LOAD; // [R4]
  assign cntZero = (cnt_reg == '0);
  assign cnt_next = load ? loadValue :
                    (cntZero ? cnt_reg : cnt_reg - DELAY_CNT_W'(1));
  assign expired = cntZero && !load;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

`default_nettype wire

/* hw/reset_sequence_supply_monitor.sv */
// Contract
// R1: a pulse on the reset pin, a low-supply reset and a watchdog reset each start one sequence.
// R2: every cause acts on the reset pin, which is driven low through the whole delay phase.
// R3: the sequence runs an active phase, then a stabilisation delay, then a vector fetch.
// R4: the delay is 256 or 4096 clock cycles, picked by an option strap read at configuration.
// R5: after the delay the 16-bit reset address is read from the top two bytes of the map.
// R6: the vector fetch takes exactly two clock cycles before execution begins.
// R7: the reset pin is an input and an open-drain output that is only ever pulled low.
// R8: outside circuitry may reset the device by holding the pin low for the minimum pulse width.
// R9: a pin pulse is caught without the clock, so it is seen even with the clock stopped.
// R10: the pin is held low while a low-supply reset is active.
// R11: the low-supply detector is enabled by an option strap and gives no reset when disabled.
// R12: the early-warning comparator shows as a live read-only flag in the control/status register.
// R13: the early-warning flag and its interrupt work only while the low-supply detector is enabled.
// R14: with its interrupt enabled, every toggle of the warning flag raises an interrupt.
// R15: the board should hold the pin low while program memory is blank.
// R16: all active causes are ORed, and the delay starts only when the last one has gone.
// R17: the warning comparator is synchronised before the flag and the edge detection use it.
`timescale 1ns/1ps
`default_nettype none

module reset_sequence_supply_monitor
  import reset_seq_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // open-drain reset pin
  input wire logic rstPinIn,
  output logic rstPinOut,
  output logic rstPinOe,
  // reset causes and analog detectors
  input wire logic watchdogRst,
  input wire logic lowSupplyDet,
  input wire logic warnComp,
  // non-volatile option straps
  input wire logic optLongDelayPin,
  input wire logic optLowSupplyEnPin,
  // vector fetch from program memory
  output logic [15:0] memAddr,
  output logic memRd,
  input wire logic [DATA_W-1:0] memRdData,
  // cpu side
  output logic cpuRst_n,
  output logic cpuStart,
  output logic [15:0] resetVector,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdData,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  seq_state_e state_reg;
  seq_state_e stateNext;
  logic extLatch_reg;
  async_in_s asyncIn;
  async_in_s syncIn;
  cause_s causeNow;
  logic optLong_reg;
  logic optLsEn_reg;
  logic [ACTIVE_CNT_W-1:0] activeCnt_reg;
  logic [ACTIVE_CNT_W-1:0] activeCnt_next;
  logic warnFlag_reg;
  logic [DATA_W-1:0] causeFlags_reg;
  logic [DATA_W-1:0] causeFlags_next;
  logic [DATA_W-1:0] irqStatus_reg;
  logic [DATA_W-1:0] irqStatus_next;
  logic [DATA_W-1:0] irqMask_reg;
  logic [DATA_W-1:0] rdMux;
  logic vectorValid_reg;
  logic oeHold_reg;
  logic delayExpired;
  wire logic extCatch_n;
  wire logic anyCause;
  wire logic holdActive;
  wire logic pinDriveNext;
  wire logic delayLoad;
  wire logic lowPending;
  wire logic flagLive;
  wire logic flagRise;
  wire logic flagFall;
  wire logic [DATA_W-1:0] irqSet;
  wire logic [DATA_W-1:0] irqClr;
  wire logic [DATA_W-1:0] causeSet;
  wire logic [DATA_W-1:0] causeClr;
  wire logic [DATA_W-1:0] scsValue;
  wire logic selScs;
  wire logic selIrqStatus;
  wire logic selIrqMask;
  wire logic selVecHi;
  wire logic selVecLo;

  ////////////////////////////////////////////////////////////////////////////
  // asynchronous catch of the reset pin
  // masked while the pin is driven by this block and one cycle beyond, so
  // the own drive and the late rise of the pin after release are not taken
  // for an outside reset
  assign extCatch_n = rstPinIn | rstPinOe | oeHold_reg; // [R9] [R7]

  always_ff @(posedge core_clk or negedge extCatch_n) begin
    if (!extCatch_n) begin
      extLatch_reg <= 1'b1; // [R9] [R8]
    end else begin
      extLatch_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for everything from outside the clock domain
  assign asyncIn.extLatched = extLatch_reg;
  assign asyncIn.lowSupplyDet = lowSupplyDet;
  assign asyncIn.warnComp = warnComp;
  assign asyncIn.optLongDelay = optLongDelayPin;
  assign asyncIn.optLowSupplyEn = optLowSupplyEnPin;

  sync_two_ff #(
    .WIDTH($bits(async_in_s))
  ) inSync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .asyncIn(asyncIn),
    .syncOut(syncIn) // [R17]
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset causes
  assign causeNow.ext = syncIn.extLatched; // [R1]
  assign causeNow.lowSupply = syncIn.lowSupplyDet & optLsEn_reg; // [R1] [R11]
  assign causeNow.watchdog = watchdogRst; // [R1]
  assign anyCause = |causeNow; // [R16]
  assign holdActive = anyCause || (activeCnt_reg != '0); // [R16] [R3]

  // the watchdog pulse and power-on get a fixed active phase
  assign activeCnt_next = causeNow.watchdog ? ACTIVE_PULSE_LOAD :
                          ((state_reg == ST_ACTIVE && activeCnt_reg != '0) ?
                           activeCnt_reg - ACTIVE_CNT_W'(1) : activeCnt_reg);

  ////////////////////////////////////////////////////////////////////////////
  // sequence state machine
  always_comb begin
    stateNext = state_reg;
    case (state_reg)
      ST_ACTIVE: begin
        if (!holdActive) begin
          stateNext = ST_DELAY; // [R3] [R16]
        end
      end
      ST_DELAY: begin
        if (delayExpired) begin
          stateNext = ST_FETCH_HI; // [R3] [R4]
        end
      end
      ST_FETCH_HI: begin
        stateNext = ST_FETCH_LO; // [R6]
      end
      ST_FETCH_LO: begin
        stateNext = ST_RUN; // [R6]
      end
      ST_RUN: begin
        stateNext = ST_RUN;
      end
      default: begin
        stateNext = ST_ACTIVE;
      end
    endcase
    if (anyCause) begin
      stateNext = ST_ACTIVE; // [R1]
    end
  end

  assign delayLoad = (stateNext == ST_DELAY) && (state_reg != ST_DELAY);

  stab_delay_counter delayCnt (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .load(delayLoad),
    .longSel(optLong_reg), // [R4]
    .expired(delayExpired)
  );

  // internal causes and the whole delay pull the pin low; the running count
  // keeps the drive up to the delay with no released cycle in between
  assign pinDriveNext = (stateNext == ST_DELAY) || // [R2]
                        ((stateNext == ST_ACTIVE) &&
                         (causeNow.lowSupply || causeNow.watchdog || // [R10] [R2]
                          activeCnt_reg != '0));

  assign lowPending = (state_reg == ST_RUN) && !vectorValid_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_ACTIVE;
      activeCnt_reg <= ACTIVE_PULSE_LOAD;
      rstPinOe <= 1'b1;
      oeHold_reg <= 1'b1;
      rstPinOut <= 1'b0;
      cpuRst_n <= 1'b0;
      memRd <= 1'b0;
      memAddr <= VEC_ADDR_HI;
    end else begin
      state_reg <= stateNext;
      activeCnt_reg <= activeCnt_next;
      rstPinOe <= pinDriveNext; // [R2] [R10]
      oeHold_reg <= rstPinOe; // [R7]
      rstPinOut <= 1'b0; // [R7]
      cpuRst_n <= (stateNext == ST_RUN); // [R6]
      memRd <= (stateNext == ST_FETCH_HI) || (stateNext == ST_FETCH_LO); // [R5]
      memAddr <= (stateNext == ST_FETCH_LO) ? VEC_ADDR_LO : VEC_ADDR_HI; // [R5]
    end
  end

  // vector bytes arrive one cycle after their address
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      resetVector <= '0;
      vectorValid_reg <= 1'b0;
      cpuStart <= 1'b0;
    end else begin
      if (state_reg == ST_FETCH_LO) begin
        resetVector[15:8] <= memRdData; // [R5]
      end
      if (lowPending) begin
        resetVector[7:0] <= memRdData; // [R5]
      end
      vectorValid_reg <= (stateNext == ST_RUN) && (vectorValid_reg || lowPending);
      cpuStart <= lowPending; // [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // option straps, captured while the sequence is in its active phase
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      optLong_reg <= OPT_LONG_RST;
      optLsEn_reg <= OPT_LSEN_RST;
    end else if (state_reg == ST_ACTIVE) begin
      optLong_reg <= syncIn.optLongDelay; // [R4]
      optLsEn_reg <= syncIn.optLowSupplyEn; // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply warning flag and its events
  assign flagLive = syncIn.warnComp & optLsEn_reg; // [R13] [R17]
  assign flagRise = flagLive & ~warnFlag_reg; // [R14]
  assign flagFall = ~flagLive & warnFlag_reg; // [R14]

  assign irqSet = (DATA_W'(flagRise) << IRQ_FLAG_SET) |
                  (DATA_W'(flagFall) << IRQ_FLAG_CLR);

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  assign selScs = (regAddr == REG_SYS_CTRL_STATUS);
  assign selIrqStatus = (regAddr == REG_IRQ_STATUS);
  assign selIrqMask = (regAddr == REG_IRQ_MASK);
  assign selVecHi = (regAddr == REG_VECTOR_HI);
  assign selVecLo = (regAddr == REG_VECTOR_LO);

  assign irqClr = (regRd && selIrqStatus) ? IRQ_USED_MASK : '0;
  assign irqStatus_next = setWinsClear(irqStatus_reg, irqSet, irqClr);

  assign causeSet = DATA_W'({causeNow.watchdog, causeNow.lowSupply, causeNow.ext}) << SCS_CAUSE_LSB;
  assign causeClr = (regWr && selScs) ? (regWrData & SCS_CAUSE_MASK) : '0;
  assign causeFlags_next = setWinsClear(causeFlags_reg, causeSet, causeClr);

  // the warning flag bit ignores writes
  assign scsValue = causeFlags_reg |
                    (DATA_W'(warnFlag_reg) << SCS_WARN_FLAG) | // [R12]
                    (DATA_W'(optLong_reg) << SCS_OPT_LONG) |
                    (DATA_W'(optLsEn_reg) << SCS_OPT_LSEN);

  always_comb begin
    if (selScs) begin
      rdMux = scsValue;
    end else if (selIrqStatus) begin
      rdMux = irqStatus_reg;
    end else if (selIrqMask) begin
      rdMux = irqMask_reg;
    end else if (selVecHi) begin
      rdMux = resetVector[15:8];
    end else if (selVecLo) begin
      rdMux = resetVector[7:0];
    end else begin
      rdMux = '0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      warnFlag_reg <= 1'b0;
      causeFlags_reg <= '0;
      irqStatus_reg <= '0;
      irqMask_reg <= IRQ_MASK_RST;
      regRdData <= '0;
      irq <= 1'b0;
    end else begin
      warnFlag_reg <= flagLive; // [R12]
      causeFlags_reg <= causeFlags_next;
      irqStatus_reg <= irqStatus_next;
      if (regWr && selIrqMask) begin
        irqMask_reg <= regWrData & IRQ_USED_MASK;
      end
      regRdData <= regRd ? rdMux : '0;
      irq <= |(irqStatus_next & irqMask_reg); // [R14]
    end
  end

endmodule

`default_nettype wire

/* verification/reset_seq_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module reset_seq_props
  import reset_seq_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // pin and causes
  input wire logic rstPinIn,
  input wire logic rstPinOut,
  input wire logic rstPinOe,
  input wire logic watchdogRst,
  input wire logic lowSupplyDet,
  input wire logic optLowSupplyEnPin,
  // fetch and cpu
  input wire logic [15:0] memAddr,
  input wire logic memRd,
  input wire logic cpuRst_n,
  input wire logic cpuStart,
  // register port and interrupt
  input wire logic regRd,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // length of the current pin drive, saturating
  logic [12:0] oeCnt;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      oeCnt <= 13'h0000;
    end else begin
      oeCnt <= !rstPinOe ? 13'h0000 : (&oeCnt) ? oeCnt : oeCnt + 13'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_pin_open_drain: assert property (rstPinOut == 1'b0)
    else $error("reset pin driven high");
  a_delay_min: assert property ($fell(rstPinOe) |-> oeCnt >= 13'h0100)
    else $error("pin released before the delay ended");
  a_fetch_follows: assert property ($fell(rstPinOe) |-> $rose(memRd) && memAddr == 16'hFFFE)
    else $error("fetch does not follow the delay");
  a_fetch_two: assert property ($rose(memRd) |=> memRd && memAddr == 16'hFFFF ##1 !memRd)
    else $error("fetch not two cycles");
  a_run_after_fetch: assert property ($fell(memRd) |-> cpuRst_n ##1 cpuStart)
    else $error("cpu not started after fetch");
  a_cpu_held: assert property (rstPinOe |-> !cpuRst_n)
    else $error("cpu runs while pin driven");
  a_watchdog_acts: assert property (watchdogRst |=> !cpuRst_n && rstPinOe)
    else $error("watchdog reset not taken");
  a_ext_pin_acts: assert property ((!rstPinIn && !rstPinOe) [*4] |-> ##[0:2] !cpuRst_n)
    else $error("pin reset not taken");
  a_low_supply_pin: assert property ((lowSupplyDet && optLowSupplyEnPin) [*4] |-> ##[0:3] rstPinOe)
    else $error("pin not held in low supply");
  a_start_pulse: assert property (cpuStart |=> !cpuStart)
    else $error("start pulse too long");
  a_read_idle: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data outside read cycle");

  c_released: cover property ($fell(rstPinOe));
  c_started: cover property (cpuStart);
  c_irq: cover property ($rose(irq));
endmodule

bind reset_sequence_supply_monitor reset_seq_props u_props (
  .core_clk, .arst_n, .rstPinIn, .rstPinOut, .rstPinOe, .watchdogRst, .lowSupplyDet,
  .optLowSupplyEnPin, .memAddr, .memRd, .cpuRst_n, .cpuStart, .regRd, .regRdData, .irq
);

`default_nettype wire

/* verification/board_model.sv */
`timescale 1ns/1ps
`default_nettype none

module board_model
  import reset_seq_pkg::*;
(
  // clock
  input wire logic core_clk,
  // reset line
  input wire logic rstPinOe,
  input wire logic extPull,
  output logic rstPinIn,
  // program memory
  input wire logic [15:0] memAddr,
  input wire logic memRd,
  input wire logic [7:0] vecHi,
  input wire logic [7:0] vecLo,
  output logic [DATA_W-1:0] memRdData
);
  // weak pull-up wins only while nobody pulls low
  assign rstPinIn = !(rstPinOe || extPull);

  // data valid the cycle after a read, changing otherwise
  initial memRdData = 8'h00;
  always @(posedge core_clk) begin
    if (memRd && memAddr == 16'hFFFE) begin
      memRdData <= vecHi;
    end else if (memRd && memAddr == 16'hFFFF) begin
      memRdData <= vecLo;
    end else begin
      memRdData <= ~memRdData;
    end
  end
endmodule

`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  import reset_seq_pkg::*;
  logic core_clk = 1'b0;
  logic clkRun = 1'b1;
  logic arst_n = 1'b0;
  logic extPull = 1'b0;
  logic watchdogRst = 1'b0;
  logic lowSupplyDet = 1'b0;
  logic warnComp = 1'b0;
  logic optLong = 1'b0;
  logic optLsEn = 1'b1;
  logic [ADDR_W-1:0] regAddr = 4'h0;
  logic [DATA_W-1:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] vecHi = 8'h5A;
  logic [7:0] vecLo = 8'hC3;
  logic rstPinIn, rstPinOut, rstPinOe, memRd, cpuRst_n, cpuStart, irq;
  logic [15:0] memAddr, resetVector;
  logic [DATA_W-1:0] memRdData, regRdData, rdv;
  int n_mismatch = 0;
  int tests_run = 0;
  int oeRun = 0;
  int oeSpan = 0;

  always #50 if (clkRun) core_clk = ~core_clk;

  reset_sequence_supply_monitor uut (
    .core_clk, .arst_n, .rstPinIn, .rstPinOut, .rstPinOe, .watchdogRst, .lowSupplyDet,
    .warnComp, .optLongDelayPin(optLong), .optLowSupplyEnPin(optLsEn), .memAddr, .memRd,
    .memRdData, .cpuRst_n, .cpuStart, .resetVector, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .irq
  );
  board_model u_board (
    .core_clk, .rstPinOe, .extPull, .rstPinIn, .memAddr, .memRd, .vecHi, .vecLo, .memRdData
  );

  // length of the last pin drive
  always @(posedge core_clk) begin
    if (rstPinOe) begin
      oeRun <= oeRun + 1;
    end else begin
      if (oeRun != 0) oeSpan <= oeRun;
      oeRun <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [7:0] m, input logic [7:0] e,
                       input string what);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 rdv = regRdData;
    chk(16'(rdv & m), 16'(e), what);
  endtask

  function automatic int expSpan(input logic lng);
    return (lng ? DELAY_LONG_CYC : DELAY_SHORT_CYC) + int'(ACTIVE_PULSE_LOAD);
  endfunction

  task automatic waitStart();
    int i = 0;
    while (cpuStart !== 1'b1 && i < 6000) begin
      @(posedge core_clk);
      #1 i++;
    end
    chk(16'(cpuStart), 16'h0001, "start pulse");
    chk(16'(cpuRst_n), 16'h0001, "cpu released");
    chk(resetVector, {vecHi, vecLo}, "vector");
  endtask

  // watchdog pulse of random length with a fresh vector
  task automatic wdReset(input logic lng);
    int e = expSpan(lng);
    @(posedge core_clk);
    vecHi <= 8'($urandom);
    vecLo <= 8'($urandom);
    watchdogRst <= 1'b1;
    repeat ($urandom_range(1, 3)) @(posedge core_clk);
    watchdogRst <= 1'b0;
    waitStart();
    chk(16'(oeSpan >= e - 1 && oeSpan <= e + 5), 16'h0001, "delay length");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(20000 * 100);
    n_mismatch++;
    $display("unexpected at %0t: run timed out", $time);
    end_sim();
  end

  initial begin
    void'($urandom(23479));
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    waitStart();
    rdChk(REG_SYS_CTRL_STATUS, 8'h07, 8'h04, "options");
    wr(REG_SYS_CTRL_STATUS, 8'hFF);
    rdChk(REG_SYS_CTRL_STATUS, 8'h07, 8'h04, "read-only bits");
    rdChk(REG_VECTOR_HI, 8'hFF, vecHi, "vector hi");
    rdChk(REG_VECTOR_LO, 8'hFF, vecLo, "vector lo");
    wr(4'hF, 8'hFF);
    rdChk(4'hF, 8'hFF, 8'h00, "unmapped");
    // watchdog, short delay
    wdReset(1'b0);
    rdChk(REG_SYS_CTRL_STATUS, 8'h70, 8'h40, "watchdog cause");
    wr(REG_SYS_CTRL_STATUS, 8'h70);
    // warning flag toggles, masked and unmasked
    wr(REG_IRQ_MASK, 8'h03);
    warnComp <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1 chk(16'(irq), 16'h0001, "irq on rise");
    rdChk(REG_SYS_CTRL_STATUS, 8'h01, 8'h01, "live flag");
    rdChk(REG_IRQ_STATUS, 8'h03, 8'h01, "rise event");
    rdChk(REG_IRQ_STATUS, 8'h03, 8'h00, "read clears");
    #1 chk(16'(irq), 16'h0000, "irq cleared");
    warnComp <= 1'b0;
    repeat (6) @(posedge core_clk);
    rdChk(REG_IRQ_STATUS, 8'h03, 8'h02, "fall event");
    wr(REG_IRQ_MASK, 8'h00);
    warnComp <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1 chk(16'(irq), 16'h0000, "masked irq");
    rdChk(REG_IRQ_STATUS, 8'h03, 8'h01, "masked event");
    warnComp <= 1'b0;
    // low supply held for a while
    lowSupplyDet <= 1'b1;
    repeat (100) @(posedge core_clk);
    #1 chk(16'({rstPinOe, cpuRst_n}), 16'h0002, "low supply hold");
    lowSupplyDet <= 1'b0;
    waitStart();
    rdChk(REG_SYS_CTRL_STATUS, 8'h20, 8'h20, "low supply cause");
    // pin pulse while the clock is stopped
    @(negedge core_clk);
    clkRun = 1'b0;
    #100 extPull = 1'b1;
    #300 extPull = 1'b0;
    #300 clkRun = 1'b1;
    repeat (6) @(posedge core_clk);
    #1 chk(16'(cpuRst_n), 16'h0000, "halted pin reset");
    waitStart();
    rdChk(REG_SYS_CTRL_STATUS, 8'h10, 8'h10, "pin cause");
    // pin pulse of random length with the clock running
    wr(REG_SYS_CTRL_STATUS, 8'h70);
    extPull <= 1'b1;
    repeat ($urandom_range(6, 9)) @(posedge core_clk);
    #1 chk(16'({rstPinOe, cpuRst_n}), 16'h0000, "running pin reset");
    extPull <= 1'b0;
    waitStart();
    rdChk(REG_SYS_CTRL_STATUS, 8'h70, 8'h10, "running pin cause");
    // detector disabled
    optLsEn <= 1'b0;
    wdReset(1'b0);
    // the fall event left after the masked rise is still pending
    rdChk(REG_IRQ_STATUS, 8'h03, 8'h02, "pending fall event");
    wr(REG_IRQ_MASK, 8'h03);
    lowSupplyDet <= 1'b1;
    warnComp <= 1'b1;
    repeat (20) @(posedge core_clk);
    #1 chk(16'({rstPinOe, cpuRst_n, irq}), 16'h0002, "disabled detectors");
    rdChk(REG_SYS_CTRL_STATUS, 8'h05, 8'h00, "flag off");
    lowSupplyDet <= 1'b0;
    warnComp <= 1'b0;
    // long delay
    optLong <= 1'b1;
    optLsEn <= 1'b1;
    wdReset(1'b1);
    rdChk(REG_SYS_CTRL_STATUS, 8'h06, 8'h06, "long option");
    end_sim();
  end
endmodule

`default_nettype wire
